// ---- phy_port_status_page.sv ----
// Purpose: Port status page (page 0) of a cable PHY register file
// Assumes: Line and port status inputs are asynchronous pins
// Notes: One cycle wait state on every Wishbone access
module phy_port_status_page (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] tpa_line_state_i,
  input wire logic [1:0] tpb_line_state_i,
  input wire logic child_i,
  input wire logic connect_raw_i,
  input wire logic bias_raw_i,
  input wire logic [2:0] peer_rate_i,
  input wire logic bus_reset_i,
  input wire logic tree_id_done_i,
  input wire logic self_id_done_i,
  input wire logic resuming_i,
  input wire logic suspending_i,
  output logic port_disable_o,
  output logic port_suspend_hold_o,
  output logic port_event_o
);

  // ----------------------------------------
  // Synchroniser bit positions
  // ----------------------------------------
  localparam int unsigned SY_SUS = 0;
  localparam int unsigned SY_RES = 1;
  localparam int unsigned SY_RATE_LSB = 2;
  localparam int unsigned SY_BIAS = 5;
  localparam int unsigned SY_CON = 6;
  localparam int unsigned SY_CHILD = 7;
  localparam int unsigned SY_TPB_LSB = 8;
  localparam int unsigned SY_TPA_LSB = 10;
  localparam int unsigned SYNC_W = 12;
  localparam int unsigned SYNC_LAST = 2;
  localparam int unsigned CW = port_status_pkg::CNT_W;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [SYNC_LAST:0][SYNC_W-1:0] sync;
    logic [CW-1:0] con_cnt;
    logic [CW-1:0] bias_cnt;
    logic con;
    logic bias;
    logic dis;
    logic int_en;
    logic fault;
    logic port_event;
    logic tree_ok;
    logic self_ok;
    logic [2:0] page;
    logic [3:0] port;
    logic [3:0] snap;
    port_status_pkg::bus_state_t bst;
    logic [31:0] rdata;
    logic ack;
  } state_t;

  state_t q, d;

  localparam logic [CW-1:0] CON_MAX = CW'(port_status_pkg::CON_DEBOUNCE_CYC);
  localparam logic [CW-1:0] BIAS_MAX = CW'(port_status_pkg::BIAS_DEBOUNCE_CYC);
  localparam logic [CW-1:0] CON_LAST = CON_MAX - CW'(1);
  localparam logic [CW-1:0] BIAS_LAST = BIAS_MAX - CW'(1);

  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] s2;
  logic [SYNC_W-1:0] s3;
  logic [SYNC_W-1:0] agree;
  logic con_seen;
  logic bias_seen;
  logic resume_seen;
  logic suspend_seen;
  logic [1:0] tpa_raw;
  logic [1:0] tpb_raw;
  logic child_raw;
  logic [2:0] rate_raw;
  logic rate_bad;
  logic take;
  logic wr_take;
  logic page_port_ok;
  logic base7_wr;
  logic line_wr;
  logic peer_wr;
  logic ctrl_wr;
  logic fault_clr;
  logic event_clr;
  logic port_ok;
  logic page0;
  logic [3:0] idx;
  logic req;
  logic [7:0] line_reg;
  logic [7:0] peer_reg;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;
  logic child_v;
  logic [2:0] rate_v;
  logic [1:0] tpa_v;
  logic [1:0] tpb_v;
  logic resume_flt;
  logic suspend_flt;

  // ----------------------------------------
  // Pin capture
  // ----------------------------------------
  assign raw = {tpa_line_state_i, tpb_line_state_i, child_i, connect_raw_i,
                bias_raw_i, peer_rate_i, resuming_i, suspending_i};
  assign s2 = q.sync[SYNC_LAST-1];
  assign s3 = q.sync[SYNC_LAST];

  // Stages two and three agree, bit by bit
  for (genvar gi = 0; gi < SYNC_W; gi++) begin : g_agree
    assign agree[gi] = (s2[gi] == s3[gi]);
  end

  assign con_seen = s3[SY_CON];
  assign bias_seen = s3[SY_BIAS];
  assign resume_seen = s3[SY_RES] && agree[SY_RES];
  assign suspend_seen = s3[SY_SUS] && agree[SY_SUS];
  assign tpa_raw = s3[SY_TPA_LSB +: 2];
  assign tpb_raw = s3[SY_TPB_LSB +: 2];
  assign child_raw = s3[SY_CHILD];
  assign rate_raw = s3[SY_RATE_LSB +: 3];
  assign rate_bad = (rate_raw > port_status_pkg::RATE_S400);

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  assign take = req && (q.bst == port_status_pkg::ST_IDLE);
  assign wr_take = take && wb_we_i && wb_sel_i[0];
  assign page_port_ok = page0 && port_ok;
  assign base7_wr = wr_take && (idx == port_status_pkg::IDX_BASE7);
  assign line_wr = wr_take && page_port_ok && (idx == port_status_pkg::IDX_LINE_STATE);
  assign peer_wr = wr_take && page_port_ok && (idx == port_status_pkg::IDX_PEER_FAULT);
  assign ctrl_wr = wr_take && (idx == port_status_pkg::IDX_CTRL);
  assign fault_clr = peer_wr && wbyte[port_status_pkg::PF_FAULT];
  assign event_clr = ctrl_wr && wbyte[port_status_pkg::CT_EVENT];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    // Three-stage synchroniser; a connection, bias, resume or suspend change counts when stages two and three agree
    d.sync[0] = raw;
    d.sync[1] = q.sync[0];
    d.sync[2] = q.sync[1];

    // ----------------------------------------
    // Connection debounce
    // ----------------------------------------
    if (agree[SY_CON] && (con_seen != q.con)) begin
      if (q.con_cnt >= CON_LAST) begin
        d.con = con_seen;
        d.con_cnt = '0;
      end else begin
        d.con_cnt = q.con_cnt + 1'b1;
      end
    end else begin
      d.con_cnt = '0;
    end

    // Bias debounce
    if (agree[SY_BIAS] && (bias_seen != q.bias)) begin
      if (q.bias_cnt >= BIAS_LAST) begin
        d.bias = bias_seen;
        d.bias_cnt = '0;
      end else begin
        d.bias_cnt = q.bias_cnt + 1'b1;
      end
    end else begin
      d.bias_cnt = '0;
    end

    // ----------------------------------------
    // Bus reset invalidates tree and self-ID derived status only
    // ----------------------------------------
    if (bus_reset_i) begin
      d.tree_ok = 1'b0;
      d.self_ok = 1'b0;
    end else begin
      if (tree_id_done_i) begin
        d.tree_ok = 1'b1;
      end
      if (self_id_done_i) begin
        d.self_ok = 1'b1;
      end
    end

    // ----------------------------------------
    // Bus access
    // ----------------------------------------
    d.ack = 1'b0;
    case (q.bst)
      port_status_pkg::ST_IDLE: begin
        if (req) begin
          d.bst = port_status_pkg::ST_ACK;
          d.ack = 1'b1;
          d.rdata = {24'h000000, rd_byte};
          if (base7_wr) begin
            d.page = wbyte[port_status_pkg::B7_PAGE_LSB +: 3];
            d.port = wbyte[port_status_pkg::B7_PORT_LSB +: 4];
          end
          if (line_wr) begin
            d.dis = wbyte[port_status_pkg::LS_DIS];
          end
          if (peer_wr) begin
            d.int_en = wbyte[port_status_pkg::PF_INT_EN];
          end
          if (event_clr) begin
            d.port_event = 1'b0;
          end
        end
      end
      port_status_pkg::ST_ACK: begin
        d.bst = port_status_pkg::ST_IDLE;
      end
      default: begin
        d.bst = port_status_pkg::ST_IDLE;
      end
    endcase

    // Fault: set wins over a write-1 clear
    if (fault_clr) begin
      d.fault = 1'b0;
    end
    if (resume_flt || suspend_flt) begin
      d.fault = 1'b1;
    end

    // Port change on any watched bit change; set wins over clear
    d.snap = {d.bias, d.con, d.dis, d.fault};
    if (q.int_en && (d.snap != q.snap)) begin
      d.port_event = 1'b1;
    end
  end

  // ----------------------------------------
  // Decode and fault conditions
  // ----------------------------------------
  assign idx = wb_adr_i[5:2];
  assign wbyte = wb_dat_i[7:0];
  assign req = wb_cyc_i && wb_stb_i;
  assign page0 = (q.page == port_status_pkg::PAGE_PORT_STATUS);
  assign port_ok = (q.port <= port_status_pkg::PORT_LAST);
  assign resume_flt = resume_seen && !q.bias;
  assign suspend_flt = suspend_seen && q.bias;

  // ----------------------------------------
  // Reported fields
  // ----------------------------------------
  always_comb begin
    // Idle or invalid ports report as child
    if (!q.con || q.dis || q.fault || !q.tree_ok) begin
      child_v = 1'b1;
    end else begin
      child_v = child_raw;
    end
    // Disabled port shows invalid line state
    if (q.dis) begin
      tpa_v = port_status_pkg::LINE_INVALID;
      tpb_v = port_status_pkg::LINE_INVALID;
    end else begin
      tpa_v = tpa_raw;
      tpb_v = tpb_raw;
    end
    // Above S400 or before self-ID: first invalid code
    if (rate_bad || !q.self_ok) begin
      rate_v = port_status_pkg::RATE_S400 + 3'h1;
    end else begin
      rate_v = rate_raw;
    end
  end

  // ----------------------------------------
  // Register images and read mux
  // ----------------------------------------
  always_comb begin
    line_reg = 8'h00;
    line_reg[port_status_pkg::LS_TPA_LSB +: 2] = tpa_v;
    line_reg[port_status_pkg::LS_TPB_LSB +: 2] = tpb_v;
    line_reg[port_status_pkg::LS_CHILD] = child_v;
    line_reg[port_status_pkg::LS_CON] = q.con;
    line_reg[port_status_pkg::LS_BIAS] = q.bias;
    line_reg[port_status_pkg::LS_DIS] = q.dis;
  end

  always_comb begin
    peer_reg = 8'h00;
    peer_reg[port_status_pkg::PF_RATE_LSB +: 3] = rate_v;
    peer_reg[port_status_pkg::PF_INT_EN] = q.int_en;
    peer_reg[port_status_pkg::PF_FAULT] = q.fault;
    rd_byte = 8'h00;
    case (idx)
      port_status_pkg::IDX_BASE7: begin
        rd_byte[port_status_pkg::B7_PAGE_LSB +: 3] = q.page;
        rd_byte[port_status_pkg::B7_PORT_LSB +: 4] = q.port;
      end
      port_status_pkg::IDX_CTRL: begin
        rd_byte[port_status_pkg::CT_EVENT] = q.port_event;
      end
      port_status_pkg::IDX_LINE_STATE: begin
        if (page_port_ok) begin
          rd_byte = line_reg;
        end
      end
      port_status_pkg::IDX_PEER_FAULT: begin
        if (page_port_ok) begin
          rd_byte = peer_reg;
        end
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs, straight from the state register
  // ----------------------------------------
  assign wb_dat_o = q.rdata;
  assign wb_ack_o = q.ack;
  assign port_disable_o = q.dis;
  assign port_suspend_hold_o = q.fault;
  assign port_event_o = q.port_event;

endmodule : phy_port_status_page

// ---- port_status_pkg.sv ----
// Purpose: Constants and types for the port status page block
// Assumes: 100 MHz clock, registers reached over classic Wishbone
// Notes: Bit 0 of a PHY register is its MSB; fields are placed accordingly
package port_status_pkg;

  // ----------------------------------------
  // Clock and debounce timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CON_DEBOUNCE_MS = 341;
  localparam int unsigned BIAS_DEBOUNCE_US = 52;
  localparam int unsigned CON_DEBOUNCE_CYC = CON_DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned BIAS_DEBOUNCE_CYC = BIAS_DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W = 26;

  // ----------------------------------------
  // Register map (index, byte address = 4 * index)
  // ----------------------------------------
  localparam logic [3:0] IDX_BASE7 = 4'h7;
  localparam logic [3:0] IDX_LINE_STATE = 4'h8;
  localparam logic [3:0] IDX_PEER_FAULT = 4'h9;
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [2:0] PAGE_PORT_STATUS = 3'h0;
  localparam logic [3:0] PORT_LAST = 4'h0;

  // Base register 7 fields (reg bit n = data bit 7-n)
  localparam int unsigned B7_PAGE_LSB = 5;
  localparam int unsigned B7_PORT_LSB = 0;

  // Line/link state register data bit positions
  localparam int unsigned LS_TPA_LSB = 6;
  localparam int unsigned LS_TPB_LSB = 4;
  localparam int unsigned LS_CHILD = 3;
  localparam int unsigned LS_CON = 2;
  localparam int unsigned LS_BIAS = 1;
  localparam int unsigned LS_DIS = 0;

  // Peer/fault register data bit positions
  localparam int unsigned PF_RATE_LSB = 5;
  localparam int unsigned PF_INT_EN = 4;
  localparam int unsigned PF_FAULT = 3;

  // Control register data bit positions
  localparam int unsigned CT_EVENT = 0;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  localparam logic [1:0] LINE_INVALID = 2'h0;
  localparam logic [2:0] RATE_S400 = 3'h2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACK
  } bus_state_t;

endpackage : port_status_pkg

// ---- port_status_assertions.sv ----
// Purpose: Port checks for the port status page
// Assumes: One wait state per Wishbone access
// Notes: Bound at the foot of this file
module port_status_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic port_disable_o,
  input wire logic port_suspend_hold_o,
  input wire logic port_event_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  logic wr;
  logic dis_wr;
  logic flt_wr;
  logic evt_wr;
  assign req = wb_cyc_i && wb_stb_i;
  assign wr = req && wb_we_i;
  assign dis_wr = wr && (wb_adr_i == 6'h20);
  assign flt_wr = wr && (wb_adr_i == 6'h24) && wb_dat_i[3];
  assign evt_wr = wr && (wb_adr_i == 6'h00) && wb_dat_i[0];
  property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack too long");
  property p_req; $rose(req) |=> wb_ack_o; endproperty
  a_req: assert property (p_req) else $error("no ack");
  property p_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper data set");
  property p_rsv; wb_ack_o && !wb_we_i && wb_adr_i[5:2] >= 4'hA |-> wb_dat_o == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved not zero");
  property p_rbit; wb_ack_o && !wb_we_i && wb_adr_i == 6'h24 |-> wb_dat_o[2:0] == 3'h0; endproperty
  a_rbit: assert property (p_rbit) else $error("reserved bits set");
  property p_dis; $changed(port_disable_o) |-> $past(dis_wr); endproperty
  a_dis: assert property (p_dis) else $error("disable moved");
  property p_flt; $fell(port_suspend_hold_o) |-> $past(flt_wr);
  endproperty
  a_flt: assert property (p_flt) else $error("fault lost");
  property p_evt; $fell(port_event_o) |-> $past(evt_wr);
  endproperty
  a_evt: assert property (p_evt) else $error("event lost");
  c_read: cover property (wb_ack_o && !wb_we_i);
  c_fault: cover property ($rose(port_suspend_hold_o));
  c_event: cover property ($rose(port_event_o));
endmodule : port_status_assertions
bind phy_port_status_page port_status_assertions u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .port_disable_o,
  .port_suspend_hold_o, .port_event_o);

// ---- link_master.sv ----
// Purpose: Link-layer Wishbone master
// Assumes: Classic single cycle, slave sets the pace
// Notes: Byte in dat[7:0], sel fixed
module link_master (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [5:0] adr_o,
  output logic [31:0] dat_o,
  output logic [3:0] sel_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 6'h00;
    dat_o = 32'h0;
    sel_o = 4'h1;
  end
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
    output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= {24'h0, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    dat_o <= ~dat_o;
  endtask : xfer
endmodule : link_master

// ---- tb_phy_port_status_page.sv ----
// Purpose: Self-checking bench for the port status page
// Assumes: Tree and self identification done held high
// Notes: Connection debounce outlasts the run
module tb_phy_port_status_page;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, cyc, stb, we, ack, dis, hold, evt;
  logic rst_i = 1'b1, con = 1'b1, chd = 1'b1, bias = 1'b0, brst = 1'b0, res = 1'b0, sus = 1'b0;
  logic [1:0] tpa = 2'h3, tpb = 2'h2;
  logic [2:0] rate = 3'h1;
  logic [3:0] sel;
  logic [5:0] adr;
  logic [31:0] wd, rdat, q;
  int errors = 0, samples_checked = 0;
  link_master u_lm (.clk_i, .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .dat_o(wd), .sel_o(sel));
  phy_port_status_page DUT (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .tpa_line_state_i(tpa), .tpb_line_state_i(tpb), .child_i(chd), .connect_raw_i(con),
    .bias_raw_i(bias), .peer_rate_i(rate), .bus_reset_i(brst), .tree_id_done_i(1'b1),
    .self_id_done_i(1'b1), .resuming_i(res), .suspending_i(sus), .port_disable_o(dis),
    .port_suspend_hold_o(hold), .port_event_o(evt));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_lm.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    u_lm.xfer(1'b0, a, 8'h00, q);
    chk(q, {24'h0, e});
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial begin
    #400000;
    errors++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(3);
    rd(6'h20, 8'hE8);
    rd(6'h1C, 8'h00);
    wr(6'h24, 8'h10);
    rd(6'h24, 8'h30);
    wr(6'h20, 8'h01);
    tick(2);
    chk(dis, 1'b1);
    chk(evt, 1'b1);
    rd(6'h20, 8'h09);
    wr(6'h00, 8'h01);
    tick(2);
    chk(evt, 1'b0);
    wr(6'h20, 8'h00);
    wr(6'h00, 8'h01);
    @(posedge clk_i) bias <= 1'b1;
    tick(5000);
    rd(6'h20, 8'hE8);
    tick(300);
    rd(6'h20, 8'hEA);
    chk(evt, 1'b1);
    $display("control and debounce done");
    for (int r = 0; r < 8; r++) begin
      @(posedge clk_i) rate <= r[2:0];
      tick(5);
      rd(6'h24, {((r > 2) ? 3'h3 : r[2:0]), 5'h10});
    end
    @(posedge clk_i) sus <= 1'b1;
    tick(10);
    chk(hold, 1'b1);
    rd(6'h24, 8'h78);
    @(posedge clk_i) sus <= 1'b0;
    wr(6'h24, 8'h10);
    tick(2);
    chk(hold, 1'b1);
    wr(6'h24, 8'h18);
    tick(2);
    chk(hold, 1'b0);
    @(posedge clk_i) bias <= 1'b0;
    tick(6000);
    @(posedge clk_i) res <= 1'b1;
    tick(10);
    chk(hold, 1'b1);
    @(posedge clk_i) res <= 1'b0;
    tick(5);
    wr(6'h24, 8'h18);
    $display("rate and fault done");
    wr(6'h1C, 8'h01);
    rd(6'h20, 8'h00);
    rd(6'h24, 8'h00);
    wr(6'h24, 8'h00);
    wr(6'h1C, 8'h00);
    rd(6'h24, 8'h70);
    rd(6'h28, 8'h00);
    wr(6'h3C, 8'hFF);
    rd(6'h3C, 8'h00);
    wr(6'h20, 8'h01);
    @(posedge clk_i) brst <= 1'b1;
    @(posedge clk_i) brst <= 1'b0;
    tick(10);
    chk(dis, 1'b1);
    u_lm.xfer(1'b0, 6'h24, 8'h00, q);
    chk(q[4], 1'b1);
    $display("select and bus reset done");
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(1);
    chk(dis, 1'b0);
    tick(3);
    rd(6'h24, 8'h60);
    $display("reset done");
    give_verdict();
  end
endmodule : tb_phy_port_status_page
